/* logic/scb_register_bank.sv */
// Purpose: serial-port configuration register bank with gain trim code generation
// Assumes: host frames with select low, data sampled on rising serial clock
// Notes: serial clock only runs inside frames; writes cross to clk by a toggle
//
// Contract
// [R1] select low frames one serial transaction
// [R2] data in sampled on rising serial clock
// [R3] read data pulled low, open-drain output
// [R4] enable high on, enable low off
// [R5] nine addressed 8-bit control registers
// [R6] registers hold documented defaults when unwritten
// [R7] soft reset bit restores all defaults
// [R8] soft reset bit self-clears after 50ns
// [R9] four 11-bit gain trim dacs
// [R10] dac codes 64 to 2047, 0 shutdown
// [R11] dac codes derived internally, never written
// [R12] each coarse step loads one hardwired code
// [R13] coarse gain is gain register bits 4:0
// [R14] code 0 is 0dB, 19 is -19dB
// [R15] host never writes reserved codes 20-31
// [R16] strobe mode refreshes temperature on rising pin
// [R17] gain bit 5 switches Q-channel off
// [R18] gain bit 6 enables analog gain control
`timescale 1ns/1ps
module scb_register_bank
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic chip_enable,
  input wire logic temp_update_strobe,
  output logic chip_on,
  output logic [7:0] lo_tuning,
  output logic [7:0] gain_control,
  output logic [7:0] i_channel_offset,
  output logic [7:0] q_channel_offset,
  output logic [7:0] iq_gain_ratio,
  output logic [7:0] iq_phase_balance,
  output logic [7:0] lo_match_override,
  output logic [7:0] temp_correction_override,
  output logic [7:0] operating_mode,
  output logic [4:0] coarse_gain_code,
  output logic q_channel_off,
  output logic analog_gain_enable,
  output logic temp_update_select,
  output logic temp_refresh,
  output logic [10:0] dac_code_bbpi,
  output logic [10:0] dac_code_bbmi,
  output logic [10:0] dac_code_bbpq,
  output logic [10:0] dac_code_bbmq
);

  // hardwired trim code for a coarse gain value; reserved codes clamp to the last step
  function automatic logic [10:0] gain_dac(input logic [4:0] code);
    logic [4:0] idx;
    idx = (code < GAIN_STEPS) ? code : 5'(GAIN_STEPS - 5'h01);
    return GAIN_DAC_TABLE[idx];
  endfunction

  // register readback with zero for unmapped addresses
  function automatic logic [7:0] reg_byte(input logic [8:0][7:0] bank, input logic [6:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr < REG_LIMIT) begin
      val = bank[addr[3:0]];
    end
    return val;
  endfunction

  scb_frame_s f;
  scb_frame_s next_f;
  scb_post_s p;
  scb_post_s next_p;
  scb_core_s c;
  scb_core_s next_c;
  logic frame_rst;
  logic wr_hit;
  logic [4:0] gain_code;

  // ---------------- link domain (serial clock) ----------------

  // frame state is held in reset whenever select is high
  // [R1] select frames transaction
  assign frame_rst = rst | serial_select_n;

  // shift in command and data, load read byte, post writes
  always_comb begin
    next_f = f;
    next_p = p;
    // [R2] sample data in
    if (f.cnt < CMD_BITS) begin
      next_f.cmd = {f.cmd[6:0], sdi};
    end else begin
      next_f.dat = {f.dat[6:0], sdi};
    end
    if (f.cnt != FRAME_BITS) begin
      next_f.cnt = 5'(f.cnt + 5'h01);
    end
    if (f.cnt == 5'(CMD_BITS - 5'h01)) begin
      // [R3] load read byte
      next_f.rd = f.cmd[RD_FLAG_BIT - 1];
      next_f.tx = reg_byte(c.shadow, {f.cmd[5:0], sdi});
    end else if (f.rd) begin
      next_f.tx = {f.tx[6:0], 1'b0};
    end
    // [R5] post write word
    if (f.cnt == 5'(FRAME_BITS - 5'h01) && !f.cmd[RD_FLAG_BIT]) begin
      next_p.addr = f.cmd[6:0];
      next_p.data = {f.dat[6:0], sdi};
      next_p.tog = ~p.tog;
    end
  end

  // frame registers
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // write post registers survive the end of the frame
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  // open-drain output: only ever pulls low, pull-up gives the high level
  // [R3] open-drain read data
  assign sdo_out = 1'b0;
  assign sdo_oe_n = ~(f.rd & ~f.tx[7]);

  // ---------------- core domain (clk) ----------------

  // a write toggle edge seen after two-stage synchronisation
  assign wr_hit = c.tog_s[1] ^ c.tog_s[2];
  assign gain_code = c.regs[REG_GAIN_CONTROL[3:0]][GAIN_CODE_LSB +: GAIN_CODE_W];

  // synchronisers, register writes, soft reset, trim codes
  always_comb begin
    next_c = c;
    next_c.tog_s = {c.tog_s[1:0], p.tog};
    next_c.sel_s = {c.sel_s[0], serial_select_n};
    next_c.en_s = {c.en_s[0], chip_enable};
    next_c.str_s = {c.str_s[1:0], temp_update_strobe};
    // [R8] soft reset countdown
    if (c.sr_cnt != 2'h0) begin
      next_c.sr_cnt = 2'(c.sr_cnt - 2'h1);
      if (c.sr_cnt == 2'h1) begin
        next_c.regs[REG_OPER_MODE[3:0]][SOFT_RESET_REQUEST_BIT] = 1'b0;
      end
    end
    // [R5] apply posted write
    if (wr_hit && p.addr < REG_LIMIT) begin
      if (p.addr == REG_OPER_MODE && p.data[SOFT_RESET_REQUEST_BIT]) begin
        // [R7] restore all defaults
        next_c.regs = REG_DEFAULTS;
        next_c.regs[REG_OPER_MODE[3:0]][SOFT_RESET_REQUEST_BIT] = 1'b1;
        next_c.sr_cnt = SOFT_RESET_REQUEST_CYCLES;
      end else begin
        next_c.regs[p.addr[3:0]] = p.data;
      end
    end
    // readback copy frozen while a frame is open
    if (c.sel_s[1]) begin
      next_c.shadow = c.regs;
    end
    // [R16] strobe-mode temperature refresh
    next_c.refresh = c.regs[REG_GAIN_CONTROL[3:0]][TEMP_SEL_BIT] & c.str_s[1] & ~c.str_s[2];
    // [R11] codes from register fields and chip enable only
    // [R12] hardwired trim codes
    for (int i = 0; i < NUM_DACS; i++) begin
      if (!c.en_s[1]) begin
        next_c.dac[i] = DAC_OFF;
      end else if (i >= 2 && c.regs[REG_GAIN_CONTROL[3:0]][Q_OFF_BIT]) begin
        // [R17] Q-channel dacs shut down
        next_c.dac[i] = DAC_OFF;
      end else begin
        // [R14] code to gain step
        next_c.dac[i] = gain_dac(gain_code);
      end
    end
  end

  // core registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // [R6] power-up defaults
      c <= '0;
      c.regs <= REG_DEFAULTS;
      c.shadow <= REG_DEFAULTS;
      c.sel_s <= 2'h3;
    end else begin
      c <= next_c;
    end
  end

  // register outputs
  // [R4] chip enable state
  assign chip_on = c.en_s[1];
  assign lo_tuning = c.regs[REG_LO_TUNING[3:0]];
  assign gain_control = c.regs[REG_GAIN_CONTROL[3:0]];
  assign i_channel_offset = c.regs[REG_I_OFFSET[3:0]];
  assign q_channel_offset = c.regs[REG_Q_OFFSET[3:0]];
  assign iq_gain_ratio = c.regs[REG_IQ_GAIN_RATIO[3:0]];
  assign iq_phase_balance = c.regs[REG_IQ_PHASE[3:0]];
  assign lo_match_override = c.regs[REG_LO_MATCH[3:0]];
  assign temp_correction_override = c.regs[REG_TEMP_CORR[3:0]];
  assign operating_mode = c.regs[REG_OPER_MODE[3:0]];
  // [R13] coarse gain field
  assign coarse_gain_code = gain_code;
  assign q_channel_off = gain_control[Q_OFF_BIT];
  // [R18] analog gain enable
  assign analog_gain_enable = gain_control[AGC_BIT];
  assign temp_update_select = gain_control[TEMP_SEL_BIT];
  assign temp_refresh = c.refresh;
  // [R9] four trim dac codes
  assign dac_code_bbpi = c.dac[0];
  assign dac_code_bbmi = c.dac[1];
  assign dac_code_bbpq = c.dac[2];
  assign dac_code_bbmq = c.dac[3];

  // ---------------- checks ----------------

  // output is released outside the read phase
  a_sdo_release: assert property (@(posedge sclk) disable iff (frame_rst) // [R3]
    !f.rd |-> sdo_oe_n)
    else $error("data out driven outside a read phase");

  // the msb of a read byte appears on data out from the frozen copy
  a_sdo_readback: assert property (@(posedge sclk) disable iff (frame_rst) // [R3]
    (f.cnt == 5'h07 && f.cmd[6]) |=> (sdo_oe_n == (reg_byte(c.shadow, f.cmd[6:0]) >= 8'h80)))
    else $error("read data bit does not match register");

  // soft reset bit stays high for two cycles then clears
  a_soft_reset_request_clear: assert property (@(posedge clk) disable iff (rst) // [R8]
    $rose(operating_mode[SOFT_RESET_REQUEST_BIT]) |-> operating_mode[SOFT_RESET_REQUEST_BIT] ##1
      operating_mode[SOFT_RESET_REQUEST_BIT] ##1 (!operating_mode[SOFT_RESET_REQUEST_BIT] || $past(wr_hit)))
    else $error("soft reset bit did not clear after 50ns");

  // soft reset restores registers 0, 1 and 5 to 7
  a_soft_reset_request_defaults: assert property (@(posedge clk) disable iff (rst) // [R7]
    $rose(operating_mode[SOFT_RESET_REQUEST_BIT]) |-> (lo_tuning == REG_DEFAULTS[0] &&
      gain_control == REG_DEFAULTS[1] && iq_phase_balance == REG_DEFAULTS[5] &&
      lo_match_override == REG_DEFAULTS[6] && temp_correction_override == REG_DEFAULTS[7]))
    else $error("soft reset left a register off its default");

  // a posted write lands in its register one cycle later
  a_write_apply: assert property (@(posedge clk) disable iff (rst) // [R5]
    (wr_hit && p.addr < REG_LIMIT && p.addr != REG_OPER_MODE) |=>
      (c.regs[$past(p.addr[3:0])] == $past(p.data)))
    else $error("posted write not applied");

  // both I trim codes follow the coarse gain table while enabled
  a_dac_map: assert property (@(posedge clk) disable iff (rst) // [R12]
    (chip_on && $stable(gain_code)) |=> (dac_code_bbpi == gain_dac($past(gain_code)) &&
      dac_code_bbmi == dac_code_bbpi))
    else $error("trim code does not match coarse gain");

  // the bbpi and bbpq trim codes are in range or shut down
  a_dac_range: assert property (@(posedge clk) disable iff (rst) // [R10]
    (dac_code_bbpi == DAC_OFF || (dac_code_bbpi >= DAC_MIN && dac_code_bbpi <= DAC_MAX)) &&
    (dac_code_bbpq == DAC_OFF || (dac_code_bbpq >= DAC_MIN && dac_code_bbpq <= DAC_MAX)))
    else $error("trim code out of range");

  // Q-channel off or chip off shuts the Q dacs
  a_q_off: assert property (@(posedge clk) disable iff (rst) // [R17]
    (q_channel_off || !chip_on) |=> (dac_code_bbpq == DAC_OFF && dac_code_bbmq == DAC_OFF))
    else $error("Q-channel dacs still active");

  // chip off shuts both I dacs within one cycle
  a_enable_off: assert property (@(posedge clk) disable iff (rst) // [R4]
    !chip_on |=> (dac_code_bbpi == DAC_OFF && dac_code_bbmi == DAC_OFF))
    else $error("I-channel dacs active while disabled");

  // refresh pulses only in strobe mode on a rising strobe
  a_temp_strobe: assert property (@(posedge clk) disable iff (rst) // [R16]
    temp_refresh |-> $past(temp_update_select) && $past(c.str_s[1]) && !$past(c.str_s[2]))
    else $error("temperature refresh without strobe edge");

  // command bits never pull the data out line
  a_sdo_cmd_phase: assert property (@(posedge sclk) disable iff (frame_rst) // [R3]
    (f.cnt < CMD_BITS) |-> sdo_oe_n)
    else $error("data out pulled during command bits");

  // a write frame never pulls the data out line
  a_sdo_write_frame: assert property (@(posedge sclk) disable iff (frame_rst) // [R3]
    (f.cnt >= CMD_BITS && !f.cmd[RD_FLAG_BIT]) |-> sdo_oe_n)
    else $error("data out pulled during a write frame");

  // readback copy holds still while a frame is open
  a_shadow_frozen: assert property (@(posedge clk) disable iff (rst) // [R3]
    !c.sel_s[1] |=> $stable(c.shadow))
    else $error("readback copy changed inside a frame");

  // writes beyond the map leave every register alone
  a_unmapped_write: assert property (@(posedge clk) disable iff (rst) // [R5]
    (wr_hit && p.addr >= REG_LIMIT && c.sr_cnt != 2'h1) |=> $stable(c.regs))
    else $error("write outside the map changed a register");

  // soft reset write loads defaults and raises only its own bit
  a_soft_reset_request_load: assert property (@(posedge clk) disable iff (rst) // [R7]
    (wr_hit && p.addr == REG_OPER_MODE && p.data[SOFT_RESET_REQUEST_BIT]) |=>
      (operating_mode == (8'h01 << SOFT_RESET_REQUEST_BIT) && gain_control == REG_DEFAULTS[1]))
    else $error("soft reset write did not load defaults");

  // strobe mode turns a rising strobe into a refresh pulse
  a_refresh_edge: assert property (@(posedge clk) disable iff (rst) // [R16]
    (temp_update_select && c.str_s[1] && !c.str_s[2]) |=> temp_refresh)
    else $error("strobe edge missed in strobe mode");

  // the refresh pulse lasts a single cycle
  a_refresh_pulse: assert property (@(posedge clk) disable iff (rst) // [R16]
    temp_refresh |=> !temp_refresh)
    else $error("temperature refresh longer than one cycle");

  // Q-channel on keeps the Q dacs at the I trim code
  a_q_on: assert property (@(posedge clk) disable iff (rst) // [R17]
    (chip_on && !q_channel_off) |=> (dac_code_bbpq != DAC_OFF && dac_code_bbmq == dac_code_bbpi))
    else $error("Q-channel dacs off while enabled");

  // a larger coarse code up to nineteen always lowers the trim code
  a_gain_order: assert property (@(posedge clk) disable iff (rst) // [R14]
    (chip_on && $past(chip_on) && coarse_gain_code < GAIN_STEPS && coarse_gain_code > $past(coarse_gain_code))
      |=> (dac_code_bbpi < $past(dac_code_bbpi)))
    else $error("gain did not fall with a larger coarse code");

  // coarse code zero gives the full-scale trim code
  a_gain_top: assert property (@(posedge clk) disable iff (rst) // [R14]
    (chip_on && coarse_gain_code == 5'h00) |=> (dac_code_bbpi == DAC_MAX))
    else $error("code zero is not the highest gain");

  // coarse code nineteen gives the lowest trim step
  a_gain_bottom: assert property (@(posedge clk) disable iff (rst) // [R12]
    (chip_on && coarse_gain_code == 5'h13) |=> (dac_code_bbpi == GAIN_DAC_TABLE[19]))
    else $error("code nineteen is not the lowest gain");

endmodule

/* common/scb_pkg.sv */
// Purpose: shared constants and state types of the serial configuration register bank
// Assumes: 8-bit registers, 11-bit gain trim codes, core clock of 40 MHz
// Notes: gain trim codes are hardwired, one per coarse gain step
package scb_pkg;

  // register map
  localparam int NUM_REGS = 9;
  localparam logic [6:0] REG_LO_TUNING = 7'h00;
  localparam logic [6:0] REG_GAIN_CONTROL = 7'h01;
  localparam logic [6:0] REG_I_OFFSET = 7'h02;
  localparam logic [6:0] REG_Q_OFFSET = 7'h03;
  localparam logic [6:0] REG_IQ_GAIN_RATIO = 7'h04;
  localparam logic [6:0] REG_IQ_PHASE = 7'h05;
  localparam logic [6:0] REG_LO_MATCH = 7'h06;
  localparam logic [6:0] REG_TEMP_CORR = 7'h07;
  localparam logic [6:0] REG_OPER_MODE = 7'h08;
  localparam logic [6:0] REG_LIMIT = 7'h09;

  // power-up defaults, index 8 first
  localparam logic [8:0][7:0] REG_DEFAULTS = {
    8'h00, 8'h06, 8'h50, 8'h10, 8'h80, 8'h80, 8'h80, 8'h84, 8'h2e
  };

  // field positions
  localparam int GAIN_CODE_LSB = 0;
  localparam int GAIN_CODE_W = 5;
  localparam int Q_OFF_BIT = 5;
  localparam int AGC_BIT = 6;
  localparam int TEMP_SEL_BIT = 7;
  localparam int SOFT_RESET_REQUEST_BIT = 3;
  localparam int RD_FLAG_BIT = 7;

  // serial frame: command byte (read flag, 7-bit address) then data byte, msb first
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // trim dacs
  localparam int NUM_DACS = 4;
  localparam int DAC_W = 11;
  localparam logic [10:0] DAC_MIN = 11'h040;
  localparam logic [10:0] DAC_MAX = 11'h7ff;
  localparam logic [10:0] DAC_OFF = 11'h000;
  localparam logic [4:0] GAIN_STEPS = 5'h14;
  // codes for 0 dB down to -19 dB in 1 dB steps, entry 19 first
  localparam logic [19:0][10:0] GAIN_DAC_TABLE = {
    11'h0e5, 11'h102, 11'h121, 11'h143, 11'h16c, 11'h199, 11'h1cb, 11'h202, 11'h241, 11'h287,
    11'h2d7, 11'h32f, 11'h393, 11'h402, 11'h47e, 11'h50c, 11'h5a9, 11'h659, 11'h720, 11'h7ff
  };

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SOFT_RESET_REQUEST_TIME_NS = 50;
  localparam logic [1:0] SOFT_RESET_REQUEST_CYCLES = 2'((SOFT_RESET_REQUEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // link-side frame state, cleared whenever select is high
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [7:0] tx;
    logic rd;
  } scb_frame_s;

  // link-side write post, kept across frames
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic tog;
  } scb_post_s;

  // core-side state
  typedef struct packed {
    logic [8:0][7:0] regs;
    logic [8:0][7:0] shadow;
    logic [1:0] sr_cnt;
    logic [2:0] tog_s;
    logic [1:0] sel_s;
    logic [1:0] en_s;
    logic [2:0] str_s;
    logic refresh;
    logic [3:0][10:0] dac;
  } scb_core_s;

endpackage

/* verif/scb_host_model.sv */
// Purpose: host serial master that frames command and data bytes for the register bank
// Assumes: serial clock of 30 ns that stands low outside frames, pulled-up data out
// Notes: data in is flipped after each frame so a stale bit never looks valid
`timescale 1ns/1ps
module scb_host_model (
  output logic sclk,
  output logic serial_select_n,
  output logic sdi,
  input wire logic sdo_wire
);
  // idle levels
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    sdi = 1'b0;
  end

  // one frame, command byte then data byte, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {cmd, dat};
    rd = 8'h00;
    serial_select_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      // bit set up ahead of rise
      sdi = bits[15-k];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
      if (k >= 7 && k < 15) begin
        rd[14-k] = sdo_wire;
      end
    end
    #15 serial_select_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

/* verif/scb_register_bank_bench.sv */
// Purpose: self-checking bench of the serial configuration register bank
// Assumes: 40 MHz core clock, host model on the serial side
// Notes: each scenario is a task that drives and judges before it returns
`timescale 1ns/1ps
module scb_register_bank_bench;
  import scb_pkg::*;
  localparam logic [8:0][7:0] DEF = {8'h00, 8'h06, 8'h50, 8'h10, 8'h80, 8'h80, 8'h80, 8'h84, 8'h2e};
  logic clk, rst, chip_enable, temp_update_strobe;
  logic sdo_out, sdo_oe_n, chip_on, q_channel_off, analog_gain_enable, temp_update_select, temp_refresh;
  wire [8:0][7:0] regs_seen;
  logic [4:0] coarse_gain_code;
  logic [10:0] dac_pi, dac_mi, dac_pq, dac_mq;
  wire sclk, serial_select_n, sdi;
  int fails, n_tests, cycles;
  // open-drain data out with pull-up
  wire sdo_wire = sdo_oe_n ? 1'b1 : sdo_out;

  scb_register_bank scb_register_bank_i (.clk(clk), .rst(rst), .sclk(sclk),
    .serial_select_n(serial_select_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .chip_enable(chip_enable), .temp_update_strobe(temp_update_strobe), .chip_on(chip_on),
    .lo_tuning(regs_seen[0]), .gain_control(regs_seen[1]), .i_channel_offset(regs_seen[2]),
    .q_channel_offset(regs_seen[3]), .iq_gain_ratio(regs_seen[4]), .iq_phase_balance(regs_seen[5]),
    .lo_match_override(regs_seen[6]), .temp_correction_override(regs_seen[7]),
    .operating_mode(regs_seen[8]), .coarse_gain_code(coarse_gain_code), .q_channel_off(q_channel_off),
    .analog_gain_enable(analog_gain_enable), .temp_update_select(temp_update_select),
    .temp_refresh(temp_refresh), .dac_code_bbpi(dac_pi), .dac_code_bbmi(dac_mi),
    .dac_code_bbpq(dac_pq), .dac_code_bbmq(dac_mq));
  scb_host_model scb_host_model_i (.sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi),
    .sdo_wire(sdo_wire));

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // register access with the settle time the hand-over gives
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    scb_host_model_i.xfer({1'b0, a}, d, r);
    repeat (6) @(posedge clk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    scb_host_model_i.xfer({1'b1, a}, 8'h00, d);
    repeat (6) @(posedge clk);
  endtask

  task automatic t_defaults;
    @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      check(regs_seen[i], DEF[i], "default");
    end
    check(chip_on, 1'b1, "chip on");
    check(dac_pi, GAIN_DAC_TABLE[4], "default trim");
    $display("defaults done");
  endtask

  task automatic t_regs;
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(7'(i), 8'(8'h41 + i));
      rd(7'(i), r);
      check(regs_seen[i], 8'(8'h41 + i), "write");
      check(r, 8'(8'h41 + i), "readback");
    end
    wr(7'h09, 8'h00);
    rd(7'h09, r);
    check(r, 8'h00, "unmapped read");
    check(regs_seen[0], 8'h41, "unmapped write");
    check(dac_pi, GAIN_DAC_TABLE[2], "derived trim");
    $display("registers done");
  endtask

  task automatic t_gain;
    logic [10:0] prev;
    logic [4:0] c;
    prev = 11'h7ff;
    // only codes 0 to 19, never the reserved ones
    for (int i = 0; i < 20; i++) begin
      c = 5'(i);
      wr(REG_GAIN_CONTROL, {1'b0, c[1], c[0], c});
      check(coarse_gain_code, c, "coarse code");
      check(analog_gain_enable, c[1], "analog gain");
      check(q_channel_off, c[0], "q off");
      check(dac_mi, GAIN_DAC_TABLE[c], "i trim");
      check(dac_mq, c[0] ? 11'h000 : GAIN_DAC_TABLE[c], "q trim");
      check(dac_pq, c[0] ? 11'h000 : GAIN_DAC_TABLE[c], "q trim plus");
      check(dac_pi >= 11'h040, 1'b1, "trim range");
      check(i == 0 ? dac_pi == 11'h7ff : dac_pi < prev, 1'b1, "gain order");
      prev = dac_pi;
    end
    $display("gain done");
  endtask

  task automatic t_soft_reset_request;
    logic [7:0] r;
    int hi;
    hi = 0;
    scb_host_model_i.xfer({1'b0, REG_OPER_MODE}, 8'h08, r);
    repeat (10) @(negedge clk) hi += int'(regs_seen[8][3] === 1'b1);
    check(16'(hi), 16'h0002, "self clear");
    for (int i = 0; i < 9; i++) begin
      check(regs_seen[i], DEF[i], "soft reset");
    end
    $display("soft reset done");
  endtask

  task automatic t_temp;
    int n;
    for (int m = 1; m >= 0; m--) begin
      wr(REG_GAIN_CONTROL, {m[0], 7'h00});
      n = 0;
      @(posedge clk) temp_update_strobe <= 1'b1;
      repeat (8) @(negedge clk) n += int'(temp_refresh === 1'b1);
      @(posedge clk) temp_update_strobe <= 1'b0;
      check(16'(n), 16'(m), "temp refresh");
      check(temp_update_select, m[0], "strobe mode");
    end
    $display("temperature done");
  endtask

  task automatic t_enable;
    @(posedge clk) chip_enable <= 1'b0;
    repeat (4) @(negedge clk);
    check(chip_on, 1'b0, "off");
    check(dac_pi, 11'h000, "trim shutdown");
    @(posedge clk) chip_enable <= 1'b1;
    repeat (4) @(negedge clk);
    check(chip_on, 1'b1, "on again");
    $display("enable done");
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    chip_enable = 1'b1;
    temp_update_strobe = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    t_regs();
    t_gain();
    t_soft_reset_request();
    t_temp();
    t_enable();
    stop_test();
  end
endmodule
